// File: include/bpcr_pkg.sv
// Register map, field layout and shared types of the bridge control registers
package bpcr_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned DATA_W = 32;
    // Register indices; the byte address is four times the index
    localparam logic [ADDR_W-1:0] PUC_INDEX = 12'h050;
    localparam logic [ADDR_W-1:0] SCC_INDEX = 12'h052;
    localparam logic [ADDR_W-1:0] PUC_ADDR = PUC_INDEX << 2;
    localparam logic [ADDR_W-1:0] SCC_ADDR = SCC_INDEX << 2;
    // pci_unit_control fields
    localparam int unsigned PUC_ECC_SEL = 7;
    localparam int unsigned PUC_ECC_TEST = 6;
    localparam int unsigned PUC_SHUT_REDIR = 5;
    localparam int unsigned PUC_DUAL_NA = 4;
    localparam int unsigned PUC_PEER_CONC = 3;
    localparam int unsigned PUC_ERR_DRIVE = 2;
    localparam int unsigned PUC_RSVD = 1;
    localparam int unsigned PUC_GLOBAL_EN = 0;
    localparam logic [7:0] PUC_RESET = 8'h00;
    localparam logic [7:0] PUC_WMASK = 8'hFD;
    // secondary_cache_control fields
    localparam int unsigned SCC_SIZE_HI = 7;
    localparam int unsigned SCC_SIZE_LO = 6;
    localparam int unsigned SCC_SRAM_HI = 5;
    localparam int unsigned SCC_SRAM_LO = 4;
    localparam int unsigned SCC_FIRST_LEVEL_CACHE_ENABLE = 0;
    localparam logic [3:0] SCC_LOW_RESET = 4'h2;
    localparam logic [3:0] SCC_HIGH_RESET = 4'h0;
    // Field encodings
    localparam logic [1:0] L2_SIZE_NONE = 2'h0;
    localparam logic [1:0] L2_SIZE_256K = 2'h1;
    localparam logic [1:0] L2_SIZE_512K = 2'h2;
    localparam logic [1:0] L2_SIZE_RSVD = 2'h3;
    localparam logic [1:0] L2_SRAM_ONE = 2'h0;
    localparam logic [1:0] L2_SRAM_TWO = 2'h3;
    // Shutdown redirect I/O write
    localparam logic [15:0] SHUT_IO_ADDR = 16'h0092;
    localparam logic [7:0] SHUT_IO_DATA = 8'h01;
    // Straps pass two synchroniser stages before capture
    localparam logic [1:0] STRAP_WAIT = 2'h2;

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
        logic [3:0] pstrb;
    } bpcr_apb_req_s;

    typedef struct packed {
        logic [DATA_W-1:0] prdata;
        logic pready;
        logic pslverr;
    } bpcr_apb_rsp_s;

    typedef enum logic [1:0] {L2_NONE, L2_256K, L2_512K, L2_RESERVED} bpcr_l2_size_e;

    typedef enum {SHUT_IDLE, SHUT_FORWARD, SHUT_IO_WRITE} bpcr_shut_e;
endpackage : bpcr_pkg

// File: hdl/bpcr_regs.sv
// Bridge PCI unit control and secondary cache control registers with their effects
//
// Functional notes
// - Bit 7 picks ECC (1) or parity (0); ECC also selects adjusted DRAM timings.
// - Bit 6 puts DRAM accesses in ECC test mode; clear at reset.
// - Redirect clear: host shutdown special cycle is forwarded to PCI unchanged.
// - Redirect set: shutdown answered by PCI I/O write of 01h to address 92.
// - Bit 4 selects old or deadlock-safe dual-processor next-address rules.
// - Peer concurrency lets host run DRAM/L2 during unlocked non-holder peer cycles.
// - During concurrent peer cycles host-to-PCI cycles stall by withholding burst ready.
// - Without peer concurrency the host is held off its bus during peer cycles.
// - Bit 2 set makes SERR# push-pull; clear keeps it open-drain.
// - Bit 0 gates bits 4, 3 and 2 only; those stay off until it is set.
// - Hard reset loads cache control upper nibble from host address 31:28.
// - Cache control lower nibble resets to 0010.
// - Size field 7:6 captures inverted address 31:30 at reset release.
// - Software writes replace strap-derived size and SRAM fields.
// - Size decode: 00 none, 01 256K, 10 512K, 11 reserved.
// - Size 00 disables the secondary cache whatever the other bits say.
// - L2 runs only with non-zero size and first-level cache enable set.
// - SRAM field 5:4 captures inverted address 29:28 at reset release.
// - SRAM decode: 00 one bank, 11 two banks, 01 and 10 reserved.
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module bpcr_regs (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire bpcr_pkg::bpcr_apb_req_s apb_req,
    output bpcr_pkg::bpcr_apb_rsp_s apb_rsp,
    // Host address strap pins
    input wire logic [3:0] host_addr_strap,
    // DRAM controller controls
    output logic dram_ecc_mode,
    output logic dram_ecc_timing,
    output logic dram_ecc_test,
    // Shutdown handling
    input wire logic host_shutdown,
    output logic pci_special_req,
    output logic pci_io_wr_req,
    output logic [15:0] pci_io_addr,
    output logic [7:0] pci_io_data,
    input wire logic pci_cmd_ack,
    // Next-address policy
    output logic next_address_dual_policy,
    // Peer cycle arbitration
    input wire logic peer_cycle_active,
    input wire logic peer_cycle_locked,
    input wire logic peer_from_hold_requester,
    input wire logic host_pci_cycle,
    output logic cpu_bus_hold,
    output logic cpu_burst_ready_block,
    // System error pin
    input wire logic system_error,
    output logic serr_n_out,
    output logic serr_n_oe,
    // Secondary cache decode
    output bpcr_pkg::bpcr_l2_size_e l2_size,
    output logic l2_size_reserved,
    output logic l2_two_banks,
    output logic l2_sram_reserved,
    output logic l2_enable
);
    import bpcr_pkg::*;

    logic [7:0] pci_unit_control;
    logic [7:0] secondary_cache_control;
    logic [3:0] strap_meta;
    logic [3:0] strap_sync;
    logic [1:0] strap_count;
    logic strap_done;
    logic [31:0] next_rdata;
    logic hit_puc;
    logic hit_scc;
    logic setup_phase;
    logic write_take;
    bpcr_shut_e shut_state;
    logic gfe;
    logic peer_conc_eff;
    logic concurrent_ok;
    logic [DATA_W-1:0] prdata_q;
    logic [3:0] scc_high;
    logic [3:0] scc_low;
    logic puc_write;
    logic scc_write;
    logic strap_capture;
    logic shut_redirect;
    bpcr_shut_e next_shut_state;

    // Bus decode
    assign hit_puc = (apb_req.paddr == PUC_ADDR);
    assign hit_scc = (apb_req.paddr == SCC_ADDR);
    assign setup_phase = apb_req.psel && !apb_req.penable;
    assign write_take = apb_req.psel && apb_req.penable && apb_req.pwrite && apb_req.pstrb[0];
    assign puc_write = write_take && hit_puc;
    assign scc_write = write_take && hit_scc;

    // Always ready: read data is latched in the setup cycle so no wait state is needed
    assign apb_rsp = '{
        prdata: prdata_q,
        pready: 1'b1,
        pslverr: apb_req.psel && apb_req.penable && !(hit_puc || hit_scc)
    };

    always_comb begin
        next_rdata = 32'h0000_0000;
        if (hit_puc) begin
            next_rdata[7:0] = pci_unit_control;
        end else if (hit_scc) begin
            next_rdata[7:0] = secondary_cache_control;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (setup_phase && !apb_req.pwrite) begin
            prdata_q <= next_rdata;
        end
    end

    // PCI unit control register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pci_unit_control <= PUC_RESET;
        end else if (puc_write) begin
            pci_unit_control <= apb_req.pwdata[7:0] & PUC_WMASK;
        end
    end

    // Strap synchroniser; pins are not in the pclk domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_meta <= 4'h0;
            strap_sync <= 4'h0;
        end else begin
            strap_meta <= host_addr_strap;
            strap_sync <= strap_meta;
        end
    end

    // Straps are caught once, after the synchroniser has filled following release
    assign strap_capture = !strap_done && (strap_count == STRAP_WAIT);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_count <= 2'h0;
        end else if (!strap_done && (strap_count != STRAP_WAIT)) begin
            strap_count <= strap_count + 2'h1;
        end
    end

    // One-shot, so the straps never overwrite a later software write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strap_done <= 1'b0;
        end else if (strap_capture) begin
            strap_done <= 1'b1;
        end
    end

    // Cache control upper nibble: strap-loaded size and SRAM kind
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scc_high <= SCC_HIGH_RESET;
        end else if (scc_write) begin
            scc_high <= apb_req.pwdata[SCC_SIZE_HI:SCC_SRAM_LO];
        end else if (strap_capture) begin
            // A write in the capture cycle wins and the strap value is lost
            scc_high <= ~strap_sync;
        end
    end

    // Cache control lower nibble: plain storage, bit 0 is the first-level cache enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scc_low <= SCC_LOW_RESET;
        end else if (scc_write) begin
            scc_low <= apb_req.pwdata[SCC_SRAM_LO-1:0];
        end
    end

    assign secondary_cache_control = {scc_high, scc_low};

    // Enhanced features only act once the global enable is set
    assign gfe = pci_unit_control[PUC_GLOBAL_EN];

    // DRAM check scheme and test mode; not gated by the global enable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dram_ecc_mode <= 1'b0;
        end else begin
            dram_ecc_mode <= pci_unit_control[PUC_ECC_SEL];
        end
    end

    // Adjusted timings follow the scheme select one for one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dram_ecc_timing <= 1'b0;
        end else begin
            dram_ecc_timing <= pci_unit_control[PUC_ECC_SEL];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dram_ecc_test <= 1'b0;
        end else begin
            dram_ecc_test <= pci_unit_control[PUC_ECC_TEST];
        end
    end

    // Next-address policy; the policy is sampled live, so it must be set before L1 is on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            next_address_dual_policy <= 1'b0;
        end else begin
            next_address_dual_policy <= pci_unit_control[PUC_DUAL_NA] && gfe;
        end
    end

    // Shutdown handling; mode is fixed when the shutdown arrives
    assign shut_redirect = pci_unit_control[PUC_SHUT_REDIR];

    always_comb begin
        next_shut_state = shut_state;
        case (shut_state)
            SHUT_IDLE: begin
                if (host_shutdown) begin
                    if (shut_redirect) begin
                        next_shut_state = SHUT_IO_WRITE;
                    end else begin
                        next_shut_state = SHUT_FORWARD;
                    end
                end
            end
            SHUT_FORWARD, SHUT_IO_WRITE: begin
                // Shutdowns seen while a request is pending are dropped
                if (pci_cmd_ack) begin
                    next_shut_state = SHUT_IDLE;
                end
            end
            default: begin
                next_shut_state = SHUT_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            shut_state <= SHUT_IDLE;
        end else begin
            shut_state <= next_shut_state;
        end
    end

    assign pci_special_req = (shut_state == SHUT_FORWARD);
    assign pci_io_wr_req = (shut_state == SHUT_IO_WRITE);

    // Loaded with the request, so address and data stay steady while it stands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pci_io_addr <= 16'h0000;
        end else if (shut_state == SHUT_IDLE && host_shutdown) begin
            if (shut_redirect) begin
                pci_io_addr <= SHUT_IO_ADDR;
            end else begin
                pci_io_addr <= 16'h0000;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pci_io_data <= 8'h00;
        end else if (shut_state == SHUT_IDLE && host_shutdown) begin
            if (shut_redirect) begin
                pci_io_data <= SHUT_IO_DATA;
            end else begin
                pci_io_data <= 8'h00;
            end
        end
    end

    // Peer cycles: locked or hold-requester cycles always hold the host off
    assign peer_conc_eff = pci_unit_control[PUC_PEER_CONC] && gfe;
    assign concurrent_ok = peer_conc_eff && !peer_cycle_locked && !peer_from_hold_requester;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_bus_hold <= 1'b0;
        end else begin
            cpu_bus_hold <= peer_cycle_active && !concurrent_ok;
        end
    end

    // Only host-to-PCI cycles stall; DRAM and L2 cycles run on
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cpu_burst_ready_block <= 1'b0;
        end else begin
            cpu_burst_ready_block <= peer_cycle_active && concurrent_ok && host_pci_cycle;
        end
    end

    // SERR pin: open-drain drives only the low level, push-pull drives always
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serr_n_out <= 1'b1;
        end else begin
            serr_n_out <= !system_error;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serr_n_oe <= 1'b0;
        end else begin
            if (pci_unit_control[PUC_ERR_DRIVE] && gfe) begin
                serr_n_oe <= 1'b1;
            end else begin
                serr_n_oe <= system_error;
            end
        end
    end

    // Secondary cache decode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            l2_size <= L2_NONE;
        end else begin
            case (secondary_cache_control[SCC_SIZE_HI:SCC_SIZE_LO])
                L2_SIZE_NONE: l2_size <= L2_NONE;
                L2_SIZE_256K: l2_size <= L2_256K;
                L2_SIZE_512K: l2_size <= L2_512K;
                default: l2_size <= L2_RESERVED;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            l2_size_reserved <= 1'b0;
        end else begin
            l2_size_reserved <= (secondary_cache_control[SCC_SIZE_HI:SCC_SIZE_LO] == L2_SIZE_RSVD);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            l2_two_banks <= 1'b0;
        end else begin
            l2_two_banks <= (secondary_cache_control[SCC_SRAM_HI:SCC_SRAM_LO] == L2_SRAM_TWO);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            l2_sram_reserved <= 1'b0;
        end else begin
            l2_sram_reserved <= (secondary_cache_control[SCC_SRAM_HI:SCC_SRAM_LO] != L2_SRAM_ONE)
                && (secondary_cache_control[SCC_SRAM_HI:SCC_SRAM_LO] != L2_SRAM_TWO);
        end
    end

    // Reserved size still enables; a zero size or a clear bit 0 turns the cache off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            l2_enable <= 1'b0;
        end else begin
            l2_enable <= (secondary_cache_control[SCC_SIZE_HI:SCC_SIZE_LO] != L2_SIZE_NONE)
                && secondary_cache_control[SCC_FIRST_LEVEL_CACHE_ENABLE];
        end
    end
endmodule : bpcr_regs
`default_nettype wire

// File: dv/bpcr_regs_asserts.sv
// Port-level assertions for the bridge control register block
`timescale 1ns/100ps
`default_nettype none
module bpcr_regs_asserts (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus
    input wire bpcr_pkg::bpcr_apb_req_s apb_req,
    input wire bpcr_pkg::bpcr_apb_rsp_s apb_rsp,
    // DRAM controls
    input wire logic dram_ecc_mode,
    input wire logic dram_ecc_timing,
    // Shutdown handling
    input wire logic host_shutdown,
    input wire logic pci_special_req,
    input wire logic pci_io_wr_req,
    input wire logic [15:0] pci_io_addr,
    input wire logic [7:0] pci_io_data,
    input wire logic pci_cmd_ack,
    // Peer cycles and error pin
    input wire logic peer_cycle_active,
    input wire logic peer_cycle_locked,
    input wire logic peer_from_hold_requester,
    input wire logic cpu_bus_hold,
    input wire logic cpu_burst_ready_block,
    input wire logic system_error,
    input wire logic serr_n_out,
    input wire logic serr_n_oe,
    // Secondary cache decode
    input wire bpcr_pkg::bpcr_l2_size_e l2_size,
    input wire logic l2_size_reserved,
    input wire logic l2_two_banks,
    input wire logic l2_sram_reserved,
    input wire logic l2_enable
);
    import bpcr_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic pend;
    assign pend = pci_special_req | pci_io_wr_req;

    AST_ECC_TIMING: assert property (dram_ecc_timing == dram_ecc_mode)
        else $error("ECC timing differs from ECC mode");
    AST_RD_RSVD: assert property (apb_req.psel && apb_req.penable && !apb_req.pwrite
        && apb_req.paddr == PUC_ADDR |-> apb_rsp.prdata[1] == 1'h0)
        else $error("Reserved control bit read as one");
    AST_SHUT_START: assert property (!pend && host_shutdown |=> pend)
        else $error("Shutdown cycle not taken");
    AST_SHUT_IO: assert property (pci_io_wr_req |-> !pci_special_req
        && pci_io_addr == SHUT_IO_ADDR && pci_io_data == SHUT_IO_DATA)
        else $error("Redirect write has wrong address or data");
    AST_SHUT_HOLD: assert property (pend && !pci_cmd_ack |=>
        $stable({pci_special_req, pci_io_wr_req}))
        else $error("Pending shutdown request changed before ack");
    AST_SHUT_END: assert property (pend && pci_cmd_ack |=> !pend)
        else $error("Shutdown request outlived its ack");
    AST_PEER_OFF: assert property (!peer_cycle_active |=>
        !cpu_bus_hold && !cpu_burst_ready_block)
        else $error("Host held without a peer cycle");
    AST_PEER_LOCK: assert property (peer_cycle_active && (peer_cycle_locked
        || peer_from_hold_requester) |=> cpu_bus_hold && !cpu_burst_ready_block)
        else $error("Locked or holder peer cycle did not hold host");
    AST_SERR_ACT: assert property (system_error |=> !serr_n_out && serr_n_oe)
        else $error("Error not driven low on pin");
    AST_SERR_OD: assert property (!serr_n_oe |-> serr_n_out)
        else $error("Released error pin shows low level");
    AST_L2_OFF: assert property (l2_size == L2_NONE |-> !l2_enable)
        else $error("Secondary cache enabled with zero size");
    AST_L2_RSVD: assert property (l2_size_reserved == (l2_size == L2_RESERVED))
        else $error("Reserved size flag disagrees with size");
    AST_SRAM: assert property (!(l2_two_banks && l2_sram_reserved))
        else $error("SRAM kind decoded two ways");
endmodule : bpcr_regs_asserts

bind bpcr_regs bpcr_regs_asserts u_chk (.pclk, .presetn, .apb_req, .apb_rsp,
    .dram_ecc_mode, .dram_ecc_timing, .host_shutdown, .pci_special_req, .pci_io_wr_req,
    .pci_io_addr, .pci_io_data, .pci_cmd_ack, .peer_cycle_active, .peer_cycle_locked,
    .peer_from_hold_requester, .cpu_bus_hold, .cpu_burst_ready_block, .system_error,
    .serr_n_out, .serr_n_oe, .l2_size, .l2_size_reserved, .l2_two_banks,
    .l2_sram_reserved, .l2_enable);
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the bridge control register block
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module testbench;
    import bpcr_pkg::*;
    logic pclk = 1'h0;
    logic presetn = 1'h0;
    bpcr_apb_req_s apb_req = '0;
    bpcr_apb_rsp_s apb_rsp;
    logic [3:0] host_addr_strap = 4'hA;
    logic host_shutdown = 1'h0, pci_cmd_ack = 1'h0, system_error = 1'h0;
    logic peer_cycle_active = 1'h0, peer_cycle_locked = 1'h0;
    logic peer_from_hold_requester = 1'h0, host_pci_cycle = 1'h0;
    logic dram_ecc_mode, dram_ecc_timing, dram_ecc_test, pci_special_req, pci_io_wr_req;
    logic next_address_dual_policy, cpu_bus_hold, cpu_burst_ready_block, serr_n_out;
    logic serr_n_oe, l2_size_reserved, l2_two_banks, l2_sram_reserved, l2_enable;
    logic [15:0] pci_io_addr;
    logic [7:0] pci_io_data;
    bpcr_l2_size_e l2_size;
    logic [31:0] rdata;
    logic rerr;
    int errors = 0, cmp_count = 0, cycles = 0;
    logic [7:0] scc_val [4] = '{8'h01, 8'h41, 8'h80, 8'hF1};
    logic [4:0] scc_exp [4] = '{5'h00, 5'h09, 5'h10, 5'h1D};

    bpcr_regs dut (.pclk, .presetn, .apb_req, .apb_rsp, .host_addr_strap, .dram_ecc_mode,
        .dram_ecc_timing, .dram_ecc_test, .host_shutdown, .pci_special_req, .pci_io_wr_req,
        .pci_io_addr, .pci_io_data, .pci_cmd_ack, .next_address_dual_policy,
        .peer_cycle_active, .peer_cycle_locked, .peer_from_hold_requester, .host_pci_cycle,
        .cpu_bus_hold, .cpu_burst_ready_block, .system_error, .serr_n_out, .serr_n_oe,
        .l2_size, .l2_size_reserved, .l2_two_banks, .l2_sram_reserved, .l2_enable);

    always #50 pclk = ~pclk;

    task results;
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : results

    // Ceiling well above the roughly 140 cycles the sequence needs
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            errors++;
            results();
        end
    end

    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge pclk);
        apb_req.psel <= 1'h1;
        apb_req.pwrite <= w;
        apb_req.paddr <= a;
        apb_req.pwdata <= {24'h0, d};
        apb_req.pstrb <= 4'hF;
        @(posedge pclk);
        apb_req.penable <= 1'h1;
        @(posedge pclk);
        while (apb_rsp.pready !== 1'h1) @(posedge pclk);
        rdata = apb_rsp.prdata;
        rerr = apb_rsp.pslverr;
        apb_req.psel <= 1'h0;
        apb_req.penable <= 1'h0;
    endtask : apb

    task wr(input logic [11:0] a, input logic [7:0] d);
        apb(1'h1, a, d);
    endtask : wr

    task rd(input logic [11:0] a, input logic [7:0] d, input logic e);
        apb(1'h0, a, 8'h00);
        `CHK({rerr, rdata}, {e, 24'h0, d})
    endtask : rd

    // Decoded outputs lag the register by a clock, so two edges are allowed
    task settle;
        repeat (2) @(posedge pclk);
        #1;
    endtask : settle

    task drive(input logic [4:0] v);
        @(posedge pclk);
        {peer_cycle_active, peer_cycle_locked, peer_from_hold_requester, host_pci_cycle,
            system_error} <= v;
        settle();
    endtask : drive

    task shut(input logic io);
        @(posedge pclk);
        host_shutdown <= 1'h1;
        @(posedge pclk);
        host_shutdown <= 1'h0;
        repeat (3) @(posedge pclk);
        #1 `CHK({pci_special_req, pci_io_wr_req}, {~io, io})
        if (io) `CHK({pci_io_addr, pci_io_data}, 24'h009201)
        @(posedge pclk);
        pci_cmd_ack <= 1'h1;
        @(posedge pclk);
        pci_cmd_ack <= 1'h0;
        #1 `CHK({pci_special_req, pci_io_wr_req}, 2'h0)
    endtask : shut

    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'h1;
        repeat (5) @(posedge pclk);
        rd(PUC_ADDR, 8'h00, 1'h0);
        rd(SCC_ADDR, 8'h52, 1'h0);
        `CHK({l2_size, l2_sram_reserved, l2_enable}, {L2_256K, 2'h2})
        `CHK(l2_size_reserved, 1'h0)
        wr(PUC_ADDR, 8'hFF);
        rd(PUC_ADDR, 8'hFD, 1'h0);
        settle();
        `CHK({dram_ecc_mode, dram_ecc_timing, dram_ecc_test}, 3'h7)
        wr(PUC_ADDR, 8'h40);
        settle();
        `CHK({dram_ecc_mode, dram_ecc_timing, dram_ecc_test}, 3'h1)
        wr(PUC_ADDR, 8'h00);
        settle();
        `CHK({dram_ecc_mode, dram_ecc_timing, dram_ecc_test}, 3'h0)
        rd(12'h144, 8'h00, 1'h1);
        for (int i = 0; i < 4; i++) begin
            wr(SCC_ADDR, scc_val[i]);
            rd(SCC_ADDR, scc_val[i], 1'h0);
            settle();
            `CHK({l2_size, l2_two_banks, l2_sram_reserved, l2_enable}, scc_exp[i])
        end
        `CHK(l2_size_reserved, 1'h1)
        shut(1'h0);
        wr(PUC_ADDR, 8'h20);
        shut(1'h1);
        wr(PUC_ADDR, 8'h08);
        drive(5'h12);
        `CHK({cpu_bus_hold, cpu_burst_ready_block}, 2'h2)
        wr(PUC_ADDR, 8'h09);
        drive(5'h12);
        `CHK({cpu_bus_hold, cpu_burst_ready_block}, 2'h1)
        drive(5'h1A);
        `CHK({cpu_bus_hold, cpu_burst_ready_block}, 2'h2)
        drive(5'h10);
        `CHK({cpu_bus_hold, cpu_burst_ready_block}, 2'h0)
        wr(PUC_ADDR, 8'h04);
        drive(5'h12);
        `CHK({cpu_bus_hold, serr_n_oe, serr_n_out}, 3'h5)
        wr(PUC_ADDR, 8'h05);
        drive(5'h00);
        `CHK({serr_n_oe, serr_n_out}, 2'h3)
        drive(5'h01);
        `CHK({serr_n_oe, serr_n_out}, 2'h2)
        wr(PUC_ADDR, 8'h10);
        settle();
        `CHK(next_address_dual_policy, 1'h0)
        wr(PUC_ADDR, 8'h11);
        settle();
        `CHK(next_address_dual_policy, 1'h1)
        // Second reset with other straps proves the capture repeats
        @(posedge pclk);
        presetn <= 1'h0;
        host_addr_strap <= 4'h5;
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        repeat (5) @(posedge pclk);
        rd(SCC_ADDR, 8'hA2, 1'h0);
        rd(PUC_ADDR, 8'h00, 1'h0);
        results();
    end
endmodule : testbench
`default_nettype wire
